// *** lppf_pkg.sv ***
package lppf_pkg;

	// Clock rate in kHz so that millisecond figures stay integral.
	localparam int unsigned CLK_KHZ = 200000;

	// Cell sample period, typical figure in milliseconds.
	localparam int unsigned SAMPLE_MS = 8;
	localparam int unsigned SAMPLE_CYC = SAMPLE_MS * CLK_KHZ;

	// Overvoltage response delay, typical figure in milliseconds.
	localparam int unsigned OV_DELAY_MS = 17;
	localparam int unsigned OV_DELAY_CYC = OV_DELAY_MS * CLK_KHZ;

	// Overcurrent blanking defaults: tier one 50 ms, tier two 400 us.
	localparam int unsigned TIER1_MS = 50;
	localparam int unsigned TIER1_CYC = TIER1_MS * CLK_KHZ;
	localparam int unsigned TIER2_US = 400;
	localparam int unsigned TIER2_CYC = TIER2_US * (CLK_KHZ / 1000);

	// Hiccup off time as a multiple of the tier one delay.
	localparam int unsigned OFF_RATIO = 17;

	// Counter width, wide enough for 17 times the tier one delay.
	localparam int unsigned CNT_W = 32;

	// Number of cell comparator slots.
	localparam int unsigned NCELL = 4;

	// Cell scan index width and reset value.
	localparam logic [1:0] CELL_IDX_RST = 2'h0;

	// Protection states.
	typedef enum logic [1:0] {LPPF_NORMAL, LPPF_OVCHG, LPPF_SLEEP,
		LPPF_UVCHG} lppf_state_t;

	// Overcurrent states.
	typedef enum logic [1:0] {LPPF_OC_IDLE, LPPF_OC_BLANK1, LPPF_OC_OFF}
		lppf_oc_t;

endpackage

// *** lppf_timer.sv ***
`timescale 1ns/1ps

// Qualification counter: counts while the condition holds, clears otherwise,
// and raises done once the condition has held for the limit in cycles.
module lppf_timer
	import lppf_pkg::*;
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Condition and limit.
	input wire logic i_run,
	input wire logic [CNT_W-1:0] i_limit,
	// Result.
	output logic o_done
);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;

	// Saturating count of consecutive cycles with the condition true.
	always_comb
	begin
		next_cnt = cnt;
		if (!i_run)
			next_cnt = '0;
		else if (cnt < i_limit)
			next_cnt = cnt + 1'b1;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			cnt <= '0;
		else
			cnt <= next_cnt;
	end

	assign o_done = i_run && (cnt >= i_limit) && (i_limit != '0);

endmodule

// *** lppf_protect.sv ***
`timescale 1ns/1ps

module lppf_protect
	import lppf_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
	parameter int unsigned OV_DELAY_CYCLES = OV_DELAY_CYC,
	parameter int unsigned TIER1_CYCLES = TIER1_CYC,
	parameter int unsigned TIER2_CYCLES = TIER2_CYC
)
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Per-cell comparator results, one bit per cell slot.
	input wire logic [NCELL-1:0] i_cell_over,
	input wire logic [NCELL-1:0] i_cell_under,
	input wire logic [NCELL-1:0] i_cell_ovr_clear,
	input wire logic [NCELL-1:0] i_cell_uv_clear,
	// Current-sense comparators on the sense low node.
	input wire logic i_sense_smart,
	input wire logic i_sense_tier1,
	input wire logic i_sense_tier2,
	// Pack control pins.
	input wire logic i_wakeup_sense,
	input wire logic i_charge_permit_in,
	input wire logic i_cell_count_select,
	// FET drives and status.
	output logic o_charge_fet_drive,
	output logic o_discharge_fet_drive,
	output logic o_sleep,
	output logic [1:0] o_cell_idx
);

	localparam logic [CNT_W-1:0] SAMPLE_LIM = CNT_W'(SAMPLE_CYCLES);
	localparam logic [CNT_W-1:0] OVD_LIM = CNT_W'(OV_DELAY_CYCLES);
	localparam logic [CNT_W-1:0] T1_LIM = CNT_W'(TIER1_CYCLES);
	localparam logic [CNT_W-1:0] T2_LIM = CNT_W'(TIER2_CYCLES);
	localparam logic [CNT_W-1:0] OFF_LIM = CNT_W'(OFF_RATIO * TIER1_CYCLES);

	lppf_state_t state;
	lppf_state_t next_state;
	lppf_oc_t oc;
	lppf_oc_t next_oc;
	logic [1:0] idx;
	logic [1:0] next_idx;
	logic [CNT_W-1:0] scnt;
	logic [CNT_W-1:0] next_scnt;
	logic [CNT_W-1:0] ocnt;
	logic [CNT_W-1:0] next_ocnt;
	logic [NCELL-1:0] ov_seen;
	logic [NCELL-1:0] next_ov_seen;
	logic [NCELL-1:0] uv_seen;
	logic [NCELL-1:0] next_uv_seen;
	logic [NCELL-1:0] ovr_ok;
	logic [NCELL-1:0] next_ovr_ok;
	logic [NCELL-1:0] uvr_ok;
	logic [NCELL-1:0] next_uvr_ok;
	logic charge_fet_drive;
	logic next_chg;
	logic discharge_fet_drive;
	logic next_discharge_fet_drive;
	logic [1:0] last_idx;
	logic scan_end;
	logic any_ov;
	logic any_uv;
	logic all_ovr;
	logic all_uvr;
	logic wake_prev;
	logic next_wake_prev;
	logic wake_rise;
	logic ov_done;
	logic t1_done;
	logic t2_done;
	logic hiccup_off;

	// Pin low or open selects four cells; tied high selects three.
	assign last_idx = i_cell_count_select ? 2'h2 : 2'h3;
	assign scan_end = (idx == last_idx) && (scnt == '0);

	// Results latched over one scan; the full scan gives the verdicts.
	assign any_ov = |(ov_seen | ({3'h0, 1'b1} << idx & {NCELL{1'b0}}));
	assign any_uv = |uv_seen;
	assign all_ovr = &ovr_ok;
	assign all_uvr = &uvr_ok;
	assign wake_rise = i_wakeup_sense && !wake_prev;

	// Overvoltage must persist for the response delay before charge drops.
	lppf_timer u_ov_delay (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_run(any_ov && state == LPPF_NORMAL),
		.i_limit(OVD_LIM),
		.o_done(ov_done)
	);

	// Tier one blanking, qualified only while not already in hiccup off.
	lppf_timer u_tier1 (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_run(i_sense_tier1 && oc != LPPF_OC_OFF),
		.i_limit(T1_LIM),
		.o_done(t1_done)
	);

	// Tier two blanking, shorter, same qualification.
	lppf_timer u_tier2 (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_run(i_sense_tier2 && oc != LPPF_OC_OFF),
		.i_limit(T2_LIM),
		.o_done(t2_done)
	);

	assign hiccup_off = (oc == LPPF_OC_OFF);

	// Cell scan: one slot per sample tick, verdict sets rebuilt each pass.
	always_comb
	begin
		next_idx = idx;
		next_scnt = scnt;
		next_ov_seen = ov_seen;
		next_uv_seen = uv_seen;
		next_ovr_ok = ovr_ok;
		next_uvr_ok = uvr_ok;
		if (scnt >= SAMPLE_LIM / CNT_W'(NCELL))
		begin
			next_scnt = '0;
			// Compare the current slot and record its class.
			next_ov_seen[idx] = i_cell_over[idx];
			next_uv_seen[idx] = i_cell_under[idx];
			next_ovr_ok[idx] = i_cell_ovr_clear[idx];
			next_uvr_ok[idx] = i_cell_uv_clear[idx];
			next_idx = (idx == last_idx) ? CELL_IDX_RST : idx + 2'h1;
		end
		else
			next_scnt = scnt + 1'b1;
		// Unused slot in three-cell mode never votes.
		if (i_cell_count_select)
		begin
			next_ov_seen[3] = 1'b0;
			next_uv_seen[3] = 1'b0;
			next_ovr_ok[3] = 1'b1;
			next_uvr_ok[3] = 1'b1;
		end
	end

	// Protection state machine and FET decisions.
	always_comb
	begin
		next_state = state;
		next_wake_prev = i_wakeup_sense;
		next_chg = charge_fet_drive;
		next_discharge_fet_drive = discharge_fet_drive;
		case (state)
			LPPF_NORMAL:
			begin
				if (any_uv)
					next_state = LPPF_SLEEP;
				else if (ov_done)
					next_state = LPPF_OVCHG;
			end
			LPPF_OVCHG:
			begin
				if (any_uv)
					next_state = LPPF_SLEEP;
				else if (all_ovr && !any_ov)
					next_state = LPPF_NORMAL;
			end
			LPPF_SLEEP:
			begin
				if (wake_rise)
					next_state = LPPF_UVCHG;
			end
			LPPF_UVCHG:
			begin
				// One sample period of charge, then re-check.
				if (ocnt >= SAMPLE_LIM)
				begin
					if (all_uvr && !any_uv)
						next_state = LPPF_NORMAL;
					else
						next_state = LPPF_SLEEP;
				end
			end
			default:
				next_state = LPPF_SLEEP;
		endcase
		// Charge drive: high allows charge, low blocks it.
		case (next_state)
			LPPF_NORMAL:
				next_chg = i_charge_permit_in;
			LPPF_OVCHG:
				next_chg = i_sense_smart;
			LPPF_UVCHG:
				next_chg = i_charge_permit_in;
			default:
				next_chg = 1'b0;
		endcase
		// Discharge drive: high blocks discharge; overcurrent or hiccup off also blocks it outside sleep and undercharge charging.
		case (next_state)
			LPPF_SLEEP:
				next_discharge_fet_drive = 1'b1;
			LPPF_UVCHG:
				next_discharge_fet_drive = 1'b0;
			default:
				next_discharge_fet_drive = hiccup_off || t1_done || t2_done;
		endcase
	end

	// Hiccup controller and the sample-period counter in undercharge charging.
	always_comb
	begin
		next_oc = oc;
		next_ocnt = ocnt;
		case (oc)
			LPPF_OC_IDLE:
			begin
				next_ocnt = (state == LPPF_UVCHG) ? ocnt + 1'b1 : '0;
				if (state == LPPF_SLEEP || state == LPPF_UVCHG)
					next_oc = LPPF_OC_IDLE;
				else if (t1_done || t2_done)
				begin
					next_oc = LPPF_OC_OFF;
					next_ocnt = '0;
				end
			end
			LPPF_OC_OFF:
			begin
				next_ocnt = ocnt + 1'b1;
				// Both tiers share the off period set by delay one.
				if (ocnt >= OFF_LIM - 1'b1)
				begin
					next_oc = LPPF_OC_IDLE;
					next_ocnt = '0;
				end
				if (next_state == LPPF_SLEEP)
				begin
					next_oc = LPPF_OC_IDLE;
					next_ocnt = '0;
				end
			end
			default:
			begin
				next_oc = LPPF_OC_IDLE;
				next_ocnt = '0;
			end
		endcase
		if (state != next_state && next_state == LPPF_UVCHG)
			next_ocnt = '0;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state <= LPPF_NORMAL;
			oc <= LPPF_OC_IDLE;
			idx <= CELL_IDX_RST;
			scnt <= '0;
			ocnt <= '0;
			ov_seen <= '0;
			uv_seen <= '0;
			ovr_ok <= '1;
			uvr_ok <= '1;
			charge_fet_drive <= 1'b0;
			discharge_fet_drive <= 1'b1;
			wake_prev <= 1'b0;
		end
		else
		begin
			state <= next_state;
			oc <= next_oc;
			idx <= next_idx;
			scnt <= next_scnt;
			ocnt <= next_ocnt;
			ov_seen <= next_ov_seen;
			uv_seen <= next_uv_seen;
			ovr_ok <= next_ovr_ok;
			uvr_ok <= next_uvr_ok;
			charge_fet_drive <= next_chg;
			discharge_fet_drive <= next_discharge_fet_drive;
			wake_prev <= next_wake_prev;
		end
	end

	assign o_charge_fet_drive = charge_fet_drive;
	assign o_discharge_fet_drive = discharge_fet_drive;
	assign o_sleep = (state == LPPF_SLEEP);
	assign o_cell_idx = idx;

endmodule

// *** lppf_pack_model.sv ***
`timescale 1ns/1ps

// Stack, charger and FET model. Each cell is a 2-bit code: 0 normal,
// 1 under, 2 over or open tap, 3 inside the overcharge band.
module lppf_pack_model
	import lppf_pkg::*;
(
	// Settings from the bench.
	input wire logic [7:0] i_cells,
	input wire logic [1:0] i_load,
	input wire logic i_charger,
	// FET drives from the controller.
	input wire logic i_chg,
	input wire logic i_discharge_fet_drive,
	// Comparator levels and wake-up sense.
	output logic [NCELL-1:0] o_over,
	output logic [NCELL-1:0] o_under,
	output logic [NCELL-1:0] o_oclr,
	output logic [NCELL-1:0] o_uclr,
	output logic [2:0] o_sense,
	output logic o_wake
);
	// No load current flows while discharge is blocked.
	always_comb
	begin
		for (int i = 0; i < NCELL; i++)
		begin
			o_over[i] = i_cells[2*i+:2] == 2'h2;
			o_under[i] = i_cells[2*i+:2] == 2'h1;
			o_oclr[i] = !i_cells[2*i+1];
			o_uclr[i] = i_cells[2*i+:2] != 2'h1;
		end
		o_sense = i_discharge_fet_drive ? 3'h0 : {i_load == 2'h3, i_load[1], |i_load};
		o_wake = i_charger && !i_chg; // Wake input rises while charge is off.
	end
endmodule

// *** lppf_protect_sva.sv ***
`timescale 1ns/1ps

// Pin-level checks on the protection controller.
module lppf_protect_sva
	import lppf_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = 40,
	parameter int unsigned OV_DELAY_CYCLES = 20,
	parameter int unsigned TIER1_CYCLES = 10
)
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Watched inputs.
	input wire logic [NCELL-1:0] i_cell_over,
	input wire logic i_sense_smart,
	input wire logic i_sense_tier2,
	input wire logic i_wakeup_sense,
	input wire logic i_charge_permit_in,
	input wire logic i_cell_count_select,
	// Watched outputs.
	input wire logic o_charge_fet_drive,
	input wire logic o_discharge_fet_drive,
	input wire logic o_sleep,
	input wire logic [1:0] o_cell_idx
);
	localparam int OFF_LEN = 17 * TIER1_CYCLES;
	localparam int OV_LIM = SAMPLE_CYCLES + OV_DELAY_CYCLES + 8;
	int hi_cnt;
	int ov_cnt;
	logic any_ov;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	// Run lengths of blocked discharge and of unrelieved overvoltage.
	assign any_ov = |(i_cell_over & {!i_cell_count_select, 3'h7});
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			hi_cnt <= 0;
			ov_cnt <= 0;
		end
		else
		begin
			hi_cnt <= o_discharge_fet_drive ? hi_cnt + 1 : 0;
			ov_cnt <= (any_ov && !i_sense_smart) ? ov_cnt + 1 : 0;
		end
	end

	a_sleep_drives: assert property (o_sleep [*2] |->
		o_discharge_fet_drive && !o_charge_fet_drive) else $error("sleep");
	a_sleep_hold: assert property (o_sleep && !i_wakeup_sense |=>
		o_sleep) else $error("left sleep");
	a_wake_exit: assert property (o_sleep && $rose(i_wakeup_sense) |->
		##[1:3] !o_sleep) else $error("no wake");
	a_permit_gate: assert property ((!i_charge_permit_in
		&& !i_sense_smart) [*2] |-> !o_charge_fet_drive) else $error("permit");
	a_ov_block: assert property (ov_cnt > OV_LIM |->
		!o_charge_fet_drive) else $error("ov charge");
	a_tier2_trip: assert property ($fell(o_discharge_fet_drive)
		##0 i_sense_tier2 [*7] |-> o_discharge_fet_drive) else $error("tier2");
	a_off_time: assert property ($fell(o_discharge_fet_drive)
		&& hi_cnt > 1 && !$past(o_sleep) && !$past(o_sleep, 2) |->
		hi_cnt inside {[OFF_LEN-1:OFF_LEN+1]}) else $error("off time");
	a_idx_three: assert property (i_cell_count_select |->
		o_cell_idx != 2'h3) else $error("slot 3");
	a_idx_step: assert property (o_cell_idx != $past(o_cell_idx) |->
		o_cell_idx == $past(o_cell_idx) + 2'h1 || o_cell_idx == 2'h0)
		else $error("scan order");

	c_hiccup: cover property ($rose(o_discharge_fet_drive) && !o_sleep);
	c_wake: cover property ($fell(o_sleep));
	c_ov: cover property (ov_cnt > OV_LIM);
endmodule

bind lppf_protect lppf_protect_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES),
	.OV_DELAY_CYCLES(OV_DELAY_CYCLES), .TIER1_CYCLES(TIER1_CYCLES)) u_sva (.*);

// *** lppf_protect_tb.sv ***
`timescale 1ns/1ps

`define CHK(n, e, s) \
	samples_checked++; \
	if ((e) !== (s)) \
	begin \
		error_cnt++; \
		$display("MISMATCH %s exp %h got %h", n, e, s); \
	end

module lppf_protect_tb;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic permit = 1'b0;
	logic sel = 1'b0;
	logic chk = 1'b0;
	logic charger = 1'b0;
	logic [7:0] cells = 8'h00;
	logic [1:0] load = 2'h0;
	logic [3:0] over, under, oclr, uclr;
	logic [2:0] sense, e3;
	logic wake, charge_fet_drive, discharge_fet_drive, slp;
	logic [2:0] expq[$];
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	int k;

	// Clock at 200 MHz.
	initial
		forever
			#2.5 i_sys_clk = ~i_sys_clk;

	lppf_pack_model u_pack (.i_cells(cells), .i_load(load),
		.i_charger(charger), .i_chg(charge_fet_drive), .i_discharge_fet_drive(discharge_fet_drive), .o_over(over),
		.o_under(under), .o_oclr(oclr), .o_uclr(uclr), .o_sense(sense),
		.o_wake(wake));

	lppf_protect #(.SAMPLE_CYCLES(40), .OV_DELAY_CYCLES(20),
		.TIER1_CYCLES(10), .TIER2_CYCLES(3)) u_dut (.i_sys_clk(i_sys_clk),
		.i_rst(i_rst), .i_cell_over(over), .i_cell_under(under),
		.i_cell_ovr_clear(oclr), .i_cell_uv_clear(uclr),
		.i_sense_smart(sense[0]), .i_sense_tier1(sense[1]),
		.i_sense_tier2(sense[2]), .i_wakeup_sense(wake),
		.i_charge_permit_in(permit), .i_cell_count_select(sel),
		.o_charge_fet_drive(charge_fet_drive), .o_discharge_fet_drive(discharge_fet_drive),
		.o_sleep(slp), .o_cell_idx());

	task automatic conclude();
	begin
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	// Sets the stack, waits, then notes {charge, discharge, sleep}.
	task automatic step(input logic [7:0] c, input logic [1:0] l,
		input logic p, input int n, input logic [2:0] e);
	begin
		cells <= c;
		load <= l;
		permit <= p;
		repeat (n) @(posedge i_sys_clk);
		expq.push_back(e);
		chk <= 1'b1;
		@(posedge i_sys_clk);
		chk <= 1'b0;
	end
	endtask

	task automatic do_reset(input logic s);
	begin
		i_rst <= 1'b1;
		sel <= s;
		repeat (20) @(posedge i_sys_clk);
		i_rst <= 1'b0;
	end
	endtask

	// Compares the oldest note whenever a result is marked.
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (chk)
		begin
			e3 = expq.pop_front();
			`CHK("drives", e3, {charge_fet_drive, discharge_fet_drive, slp})
		end
		if (cyc == 3000)
		begin
			error_cnt++;
			conclude();
		end
	end

	initial
	begin
		void'($urandom(32'hF769B9F9));
		k = $urandom % 3;
		do_reset(1'b0);
		step(8'h00, 2'h0, 1'b1, 10, 3'h4);
		step(8'h00, 2'h0, 1'b0, 4, 3'h0);
		step(8'h02 << (2 * k), 2'h0, 1'b1, 90, 3'h0);
		step(8'h03 << (2 * k), 2'h1, 1'b0, 6, 3'h4);
		step(8'h03 << (2 * k), 2'h0, 1'b1, 4, 3'h0);
		step(8'h00, 2'h0, 1'b1, 60, 3'h4);
		step(8'h00, 2'h2, 1'b1, 16, 3'h6);
		step(8'h00, 2'h0, 1'b1, 200, 3'h4);
		step(8'h00, 2'h3, 1'b1, 7, 3'h6);
		step(8'h00, 2'h3, 1'b1, 178, 3'h6);
		step(8'h00, 2'h0, 1'b1, 200, 3'h4);
		step(8'h01 << (2 * k), 2'h2, 1'b1, 70, 3'h3);
		charger <= 1'b1;
		step(8'h01 << (2 * k), 2'h0, 1'b1, 6, 3'h4);
		step(8'h00, 2'h0, 1'b1, 90, 3'h4);
		charger <= 1'b0;
		do_reset(1'b1);
		step(8'h40, 2'h0, 1'b1, 90, 3'h4);
		step(8'h10, 2'h0, 1'b1, 90, 3'h3);
		conclude();
	end
endmodule
